/* glc_pkg.sv */
package glc_pkg;
  localparam logic [4:0] GLC_OFS_CTRL = 5'h09;
  localparam logic [4:0] GLC_OFS_STAT = 5'h0A;
  localparam int GLC_TEST_HI = 15;
  localparam int GLC_TEST_LO = 13;
  localparam int GLC_MAN_EN = 12;
  localparam int GLC_MAN_VAL = 11;
  localparam int GLC_PORT_TYPE = 10;
  localparam int GLC_ADV_FD = 9;
  localparam int GLC_ADV_HD = 8;
  localparam int GLC_DIAG_AUTO = 7;
  localparam logic [15:0] GLC_CTRL_WMASK = 16'hFF80;
  localparam logic [15:0] GLC_CTRL_RST = 16'h0300;
  localparam logic [7:0] GLC_CNT_MAX = 8'hFF;

  typedef enum logic [2:0]
  {
    GLC_ROLE_AUTO = 3'h1,
    GLC_ROLE_MASTER = 3'h2,
    GLC_ROLE_SLAVE = 3'h4
  } glc_role_type;

  typedef struct packed {
    logic [2:0] test_mode;
    glc_role_type role;
    logic multi_port;
    logic adv_full;
    logic adv_half;
    logic cable_diag_on_link_loss;
  } glc_ctrl_type;

  typedef struct packed {
    logic ms_fault;
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_full;
    logic lp_half;
    logic idle_err;
    logic gig_speed;
    logic link_down;
  } glc_phy_type;
endpackage

/* glc_regs.sv */
`timescale 1ns/1ps
module glc_regs #(
  parameter int ADDR_W = 5
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire glc_pkg::glc_phy_type phy_in,
  output glc_pkg::glc_ctrl_type ctrl_out,
  output logic diag_start
);
  import glc_pkg::*;

  logic [15:0] ctrl_r;
  logic fault_r;
  logic [7:0] cnt_r;
  logic [15:0] rdata_nxt;
  logic [15:0] status_view;
  logic link_down_r;
  logic diag_r;
  logic hit_ctrl;
  logic hit_stat;
  logic stat_rd;

  initial
  begin
    if (ADDR_W < 5)
      $error("glc_regs: ADDR_W must be at least 5");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // Idle errors only count while the link runs at gigabit speed
  function automatic logic idle_hit(input glc_phy_type p);
    idle_hit = p.idle_err && p.gig_speed;
  endfunction

  assign hit_ctrl = hit(reg_addr, GLC_OFS_CTRL);
  assign hit_stat = hit(reg_addr, GLC_OFS_STAT);
  assign stat_rd = reg_rd && hit_stat;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrl_r <= GLC_CTRL_RST;
    else if (reg_wr && hit_ctrl)
      ctrl_r <= reg_wdata & GLC_CTRL_WMASK;
  end

  assign ctrl_out.test_mode = ctrl_r[GLC_TEST_HI:GLC_TEST_LO];
  // role resolution; conflicts are left to the negotiation engine
  assign ctrl_out.role = !ctrl_r[GLC_MAN_EN] ? GLC_ROLE_AUTO :
                         ctrl_r[GLC_MAN_VAL] ? GLC_ROLE_MASTER : GLC_ROLE_SLAVE;
  assign ctrl_out.multi_port = ctrl_r[GLC_PORT_TYPE];
  assign ctrl_out.adv_full = ctrl_r[GLC_ADV_FD];
  assign ctrl_out.adv_half = ctrl_r[GLC_ADV_HD];
  assign ctrl_out.cable_diag_on_link_loss = ctrl_r[GLC_DIAG_AUTO];

  // diagnostic launch on link-down edge
  // Edge history resets low, but auto launch resets off, so a link already down at release launches nothing
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      link_down_r <= 1'b0;
      diag_r <= 1'b0;
    end
    else
    begin
      link_down_r <= phy_in.link_down;
      diag_r <= phy_in.link_down && !link_down_r && ctrl_r[GLC_DIAG_AUTO];
    end
  end
  assign diag_start = diag_r;

  // latch high, clear on read; a new fault wins over the read
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fault_r <= 1'b0;
    else if (phy_in.ms_fault)
      fault_r <= 1'b1;
    else if (stat_rd)
      fault_r <= 1'b0;
  end

  // idle error counter; an error coinciding with a read leaves one
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else if (stat_rd)
      cnt_r <= idle_hit(phy_in) ? 8'h01 : 8'h00;
    else if (idle_hit(phy_in) && cnt_r != GLC_CNT_MAX)
      cnt_r <= cnt_r + 8'h01;
  end

  assign status_view = {fault_r, phy_in.resolved_master, phy_in.local_rx_ok,
                        phy_in.remote_rx_ok, phy_in.lp_full, phy_in.lp_half, 2'b00, cnt_r};

  always_comb
  begin
    rdata_nxt = 16'h0000;
    if (hit_ctrl)
      rdata_nxt = ctrl_r;
    else if (hit_stat)
      rdata_nxt = status_view;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // Sequence views: a link drop seen while auto launch is on, the pulse it
  // should produce, a status read with no event racing it, and the cleared status
  sequence s_link_drop;
    !phy_in.link_down ##1 (phy_in.link_down && ctrl_r[GLC_DIAG_AUTO]);
  endsequence

  sequence s_diag_pulse;
    diag_start ##1 !diag_start;
  endsequence

  sequence s_quiet_read;
    stat_rd && !phy_in.ms_fault && !idle_hit(phy_in);
  endsequence

  sequence s_stat_cleared;
    !fault_r && cnt_r == 8'h00;
  endsequence

  a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_r[6:0] == 7'h00)
    else $error("control reserved bits nonzero");

  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && hit_ctrl |=> ctrl_r == ($past(reg_wdata) & GLC_CTRL_WMASK))
    else $error("control write not stored");

  a_ctrl_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && hit_ctrl) |=> $stable(ctrl_r))
    else $error("control changed without write");

  a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && hit_ctrl |=> reg_rdata == $past(ctrl_r))
    else $error("control read data wrong");

  a_fault_latch: assert property (@(posedge clk_sys) disable iff (rst)
    phy_in.ms_fault |=> fault_r)
    else $error("fault not latched");

  a_fault_wins: assert property (@(posedge clk_sys) disable iff (rst)
    stat_rd && phy_in.ms_fault |=> fault_r)
    else $error("fault lost to a read");

  a_fault_clear: assert property (@(posedge clk_sys) disable iff (rst)
    stat_rd && !phy_in.ms_fault |=> !fault_r)
    else $error("fault not cleared by read");

  a_fault_hold: assert property (@(posedge clk_sys) disable iff (rst)
    fault_r && !stat_rd |=> fault_r)
    else $error("fault dropped without read");

  a_fault_read: assert property (@(posedge clk_sys) disable iff (rst)
    s_quiet_read |=> s_stat_cleared)
    else $error("status not cleared by quiet read");

  a_wr_stat_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr && hit_stat && !reg_rd && !phy_in.ms_fault && !idle_hit(phy_in) |=> $stable(fault_r) && $stable(cnt_r))
    else $error("status write changed state");

  a_cnt_clear: assert property (@(posedge clk_sys) disable iff (rst)
    stat_rd && !phy_in.idle_err |=> cnt_r == 8'h00)
    else $error("counter not cleared by read");

  a_cnt_incr: assert property (@(posedge clk_sys) disable iff (rst)
    !stat_rd && idle_hit(phy_in) && cnt_r != GLC_CNT_MAX |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not increment");

  a_cnt_sat: assert property (@(posedge clk_sys) disable iff (rst)
    !stat_rd && cnt_r == GLC_CNT_MAX |=> cnt_r == GLC_CNT_MAX)
    else $error("counter wrapped");

  a_cnt_speed: assert property (@(posedge clk_sys) disable iff (rst)
    !stat_rd && !phy_in.gig_speed |=> $stable(cnt_r))
    else $error("counter moved off gigabit speed");

  a_cnt_read_hit: assert property (@(posedge clk_sys) disable iff (rst)
    stat_rd && idle_hit(phy_in) |=> cnt_r == 8'h01)
    else $error("error during read lost");

  a_cnt_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !stat_rd && !idle_hit(phy_in) |=> $stable(cnt_r))
    else $error("counter moved without error");

  a_cnt_step: assert property (@(posedge clk_sys) disable iff (rst)
    !stat_rd |=> cnt_r >= $past(cnt_r))
    else $error("counter dropped without read");

  a_role_force: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_r[GLC_MAN_EN] |-> ctrl_out.role == (ctrl_r[GLC_MAN_VAL] ? GLC_ROLE_MASTER : GLC_ROLE_SLAVE))
    else $error("manual role wrong");

  a_role_auto: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_r[GLC_MAN_EN] |-> ctrl_out.role == GLC_ROLE_AUTO)
    else $error("auto role wrong");

  a_role_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot(ctrl_out.role))
    else $error("role code not one-hot");

  a_diag_start: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(phy_in.link_down) && ctrl_r[GLC_DIAG_AUTO] |=> diag_start)
    else $error("diagnostic not launched");

  a_diag_off: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_r[GLC_DIAG_AUTO] |=> !diag_start)
    else $error("diagnostic launched while disabled");

  a_diag_seq: assert property (@(posedge clk_sys) disable iff (rst)
    s_link_drop |=> s_diag_pulse)
    else $error("diagnostic pulse malformed");

  a_diag_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !phy_in.link_down |=> !diag_start)
    else $error("diagnostic launched with link up");

  a_stat_reserved: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && hit_stat |=> reg_rdata[9:8] == 2'b00)
    else $error("status reserved bits nonzero");

  a_stat_snapshot: assert property (@(posedge clk_sys) disable iff (rst)
    stat_rd |=> reg_rdata == $past(status_view))
    else $error("status read data wrong");

  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule

/* glc_link_model.sv */
`timescale 1ns/1ps
module glc_link_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [8:0] burst,
  input wire logic load,
  input wire logic [5:0] lvl,
  input wire logic gig,
  input wire logic down,
  output glc_pkg::glc_phy_type phy_in
);
  import glc_pkg::*;
  logic [8:0] left_r;
  // One idle error per cycle until the burst is spent
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      left_r <= 9'h000;
    else if (load)
      left_r <= burst;
    else if (left_r != 9'h000)
      left_r <= left_r - 9'h001;
  end
  assign phy_in = {lvl, left_r != 9'h000, gig, down};
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import glc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  glc_phy_type phy_in;
  glc_ctrl_type ctrl_out;
  logic diag_start;
  logic [8:0] burst = 9'h000;
  logic load = 1'b0;
  logic [5:0] lvl = 6'h00;
  logic gig = 1'b0;
  logic down = 1'b0;
  int errors = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  glc_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .phy_in(phy_in), .ctrl_out(ctrl_out), .diag_start(diag_start));
  glc_link_model link (.clk_sys(clk_sys), .rst(rst), .burst(burst), .load(load), .lvl(lvl), .gig(gig),
    .down(down), .phy_in(phy_in));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe for one cycle; read data is settled just after the following edge
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic errs(input logic [8:0] n, input logic g);
    @(posedge clk_sys);
    gig <= g;
    burst <= n;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (310) @(posedge clk_sys);
  endtask
  task automatic t_reset();
    access(1'b0, GLC_OFS_CTRL, 16'h0000);
    check(reg_rdata, 16'h0300);
    access(1'b0, GLC_OFS_STAT, 16'h0000);
    check(reg_rdata, 16'h0000);
    access(1'b0, 5'h1F, 16'h0000);
    check(reg_rdata, 16'h0000);
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 8; i++)
    begin
      access(1'b1, GLC_OFS_CTRL, {i[2:0], 13'h1FFF});
      check({6'h00, ctrl_out}, {6'h00, i[2:0], 7'h2F});
    end
    access(1'b0, GLC_OFS_CTRL, 16'h0000);
    check(reg_rdata, 16'hFF80);
    access(1'b1, GLC_OFS_CTRL, 16'h1000);
    check({6'h00, ctrl_out}, 16'h0040);
    access(1'b1, GLC_OFS_CTRL, 16'h0800);
    check({6'h00, ctrl_out}, 16'h0010);
  endtask
  task automatic t_status();
    @(posedge clk_sys);
    lvl <= 6'h3F;
    @(posedge clk_sys);
    lvl <= 6'h1F;
    errs(9'h005, 1'b0);
    errs(9'h12C, 1'b1);
    access(1'b1, GLC_OFS_STAT, 16'hFFFF);
    access(1'b0, GLC_OFS_STAT, 16'h0000);
    check(reg_rdata, 16'hFCFF);
    access(1'b0, GLC_OFS_STAT, 16'h0000);
    check(reg_rdata, 16'h7C00);
    errs(9'h003, 1'b1);
    lvl <= 6'h15;
    access(1'b0, GLC_OFS_STAT, 16'h0000);
    check(reg_rdata, 16'h5403);
  endtask
  task automatic t_diag(input logic en);
    access(1'b1, GLC_OFS_CTRL, {8'h03, en, 7'h00});
    @(posedge clk_sys);
    down <= 1'b1;
    @(posedge clk_sys);
    #1;
    check({15'h0000, diag_start}, {15'h0000, en});
    @(posedge clk_sys);
    #1;
    check({15'h0000, diag_start}, 16'h0000);
    @(posedge clk_sys);
    down <= 1'b0;
  endtask
  // A reset in mid-run must restore the control defaults written over here
  task automatic t_midreset();
    access(1'b1, GLC_OFS_CTRL, 16'hFF80);
    @(posedge clk_sys);
    rst <= 1'b1;
    lvl <= 6'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
  endtask
  task automatic stop_test();
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    errors++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_status();
    t_diag(1'b1);
    t_diag(1'b0);
    t_midreset();
    stop_test();
  end
endmodule
